// ==== rtl/fic_host.sv ====
// Host controller driving a parallel NOR flash through its strobes and pins.
// Assumes one clock; flash data pins are split into in, out and enable.
`timescale 1ns/100ps
module fic_host (
   input wire logic clock,
   input wire logic reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [2:0] req_op,
   input wire logic [fic_pkg::ADDR_W-1:0] req_addr,
   input wire logic [fic_pkg::DATA_W-1:0] req_wdata,
   input wire logic req_hv_mode,
   input wire logic temp_unprotect,
   output logic rsp_valid,
   output logic [fic_pkg::DATA_W-1:0] rsp_rdata,
   output logic [fic_pkg::ADDR_W-1:0] flash_addr,
   output logic [fic_pkg::DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [fic_pkg::DATA_W-1:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic high_volt_id_addr_bit,
   output logic high_volt_reset_pin
);
   // ==========================================================
   // Sequencer state
   typedef enum logic [4:0] {
      FIC_IDLE = 5'h01,
      FIC_SETUP = 5'h02,
      FIC_PULSE = 5'h04,
      FIC_HOLD = 5'h08,
      FIC_DONE = 5'h10
   } fic_state_t;

   fic_state_t state_q, state_d;
   logic [3:0] cnt_q;
   logic [1:0] step_q;
   logic [1:0] last_step_q;
   logic is_read_q;
   logic hv_q;
   logic [2:0] op_q;
   logic [fic_pkg::ADDR_W-1:0] base_q;
   logic [fic_pkg::DATA_W-1:0] wdata_q;
   logic [fic_pkg::ADDR_W-1:0] addr_q;
   logic [fic_pkg::DATA_W-1:0] dout_q;
   logic [fic_pkg::DATA_W-1:0] rdata_q;
   logic rsp_q;
   logic [fic_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;

   // ==========================================================
   // Step decode: each op is a list of bus cycles
   function automatic logic [1:0] fic_last_step(input logic [2:0] op, input logic hv);
      if (hv || op == fic_pkg::OP_READ || op == fic_pkg::OP_RESET || op == fic_pkg::OP_WRITE)
         return 2'h0;
      return 2'h3;
   endfunction

   wire cnt_done = (cnt_q == 4'h1);
   wire step_last = (step_q == last_step_q);
   wire step_read = is_read_q && step_last;
   wire is_id_op = (op_q == fic_pkg::OP_ID_MFR) || (op_q == fic_pkg::OP_ID_DEV) ||
                   (op_q == fic_pkg::OP_ID_PROT);

   // Address selecting identification item, shared by both methods
   wire [fic_pkg::ADDR_W-1:0] id_item_ofs =
      (op_q == fic_pkg::OP_ID_MFR) ? fic_pkg::ID_MFR_OFS :
      (op_q == fic_pkg::OP_ID_DEV) ? fic_pkg::ID_DEV_OFS : fic_pkg::ID_PROT_OFS;
   // Sector address lives in high bits of base, low bits from item offset
   wire [fic_pkg::ADDR_W-1:0] id_addr =
      {base_q[fic_pkg::ADDR_W-1:fic_pkg::ADDR_W-fic_pkg::SECT_W],
       id_item_ofs[fic_pkg::ADDR_W-fic_pkg::SECT_W-1:0]};

   logic [fic_pkg::ADDR_W-1:0] step_addr;
   logic [fic_pkg::DATA_W-1:0] step_data;
   always_comb begin
      step_addr = base_q;
      step_data = wdata_q;
      if (is_id_op) begin
         unique case (step_q)
            2'h0: begin
               step_addr = hv_q ? id_addr : fic_pkg::UNLOCK1_ADDR;
               step_data = {8'h00, fic_pkg::UNLOCK1_DATA};
            end
            2'h1: begin
               step_addr = fic_pkg::UNLOCK2_ADDR;
               step_data = {8'h00, fic_pkg::UNLOCK2_DATA};
            end
            2'h2: begin
               step_addr = fic_pkg::UNLOCK1_ADDR;
               step_data = {8'h00, fic_pkg::ID_CMD_DATA};
            end
            2'h3: begin
               step_addr = id_addr;
               step_data = wdata_q;
            end
         endcase
      end else if (op_q == fic_pkg::OP_RESET) begin
         step_data = {8'h00, fic_pkg::RESET_CMD_DATA};
      end
   end

   // ==========================================================
   // Phase sequencing
   wire start = (state_q == FIC_IDLE) && req_valid;
   assign req_ready = (state_q == FIC_IDLE);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         FIC_IDLE: if (req_valid) state_d = FIC_SETUP;
         FIC_SETUP: if (cnt_done) state_d = FIC_PULSE;
         FIC_PULSE: if (cnt_done) state_d = FIC_HOLD;
         FIC_HOLD: if (cnt_done) state_d = step_last ? FIC_DONE : FIC_SETUP;
         FIC_DONE: state_d = FIC_IDLE;
      endcase
   end

   wire [3:0] pulse_len = step_read ? fic_pkg::ACCESS_CYC : fic_pkg::PULSE_CYC;
   wire [3:0] cnt_load =
      (state_d == FIC_SETUP) ? fic_pkg::SETUP_CYC :
      (state_d == FIC_PULSE) ? pulse_len : fic_pkg::HOLD_CYC;
   wire phase_change = (state_d != state_q);

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q <= FIC_IDLE;
         cnt_q <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= phase_change ? cnt_load : cnt_q - 4'h1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         op_q <= fic_pkg::OP_READ;
         hv_q <= 1'b0;
         base_q <= '0;
         wdata_q <= '0;
         last_step_q <= 2'h0;
         is_read_q <= 1'b0;
      end else if (start) begin
         op_q <= req_op;
         hv_q <= req_hv_mode && ((req_op == fic_pkg::OP_ID_MFR) ||
            (req_op == fic_pkg::OP_ID_DEV) || (req_op == fic_pkg::OP_ID_PROT));
         base_q <= req_addr;
         wdata_q <= req_wdata;
         last_step_q <= fic_last_step(req_op, req_hv_mode);
         is_read_q <= (req_op != fic_pkg::OP_RESET) && (req_op != fic_pkg::OP_WRITE);
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         step_q <= 2'h0;
      end else if (start) begin
         step_q <= 2'h0;
      end else if (state_q == FIC_HOLD && cnt_done && !step_last) begin
         step_q <= step_q + 2'h1;
      end
   end

   // ==========================================================
   // Pin drive, registered
   wire in_pulse = (state_q == FIC_PULSE) || (state_d == FIC_PULSE);
   wire cyc_active = (state_q == FIC_SETUP) || (state_q == FIC_PULSE) || (state_q == FIC_HOLD);
   wire drive_we = in_pulse && (state_d == FIC_PULSE) && !step_read;
   wire drive_oe = (state_d == FIC_PULSE) && step_read;
   wire drive_dq = (state_d == FIC_SETUP || state_d == FIC_PULSE || state_d == FIC_HOLD)
                   && !step_read;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_dq_oe <= 1'b0;
         addr_q <= '0;
         dout_q <= '0;
         high_volt_id_addr_bit <= 1'b0;
         high_volt_reset_pin <= 1'b0;
      end else begin
         // Chip select covers the whole cycle so strobes never glitch
         flash_ce_n <= !(state_d == FIC_SETUP || state_d == FIC_PULSE ||
                         state_d == FIC_HOLD);
         flash_we_n <= !drive_we;
         flash_oe_n <= !drive_oe;
         flash_dq_oe <= drive_dq;
         addr_q <= step_addr;
         dout_q <= step_data;
         high_volt_id_addr_bit <= (state_d != FIC_IDLE) && (state_d != FIC_DONE) && hv_q;
         high_volt_reset_pin <= temp_unprotect;
      end
   end
   assign flash_addr = addr_q;
   assign flash_dq_out = dout_q;

   // ==========================================================
   // Read data capture through two flops
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
         rdata_q <= '0;
         rsp_q <= 1'b0;
      end else begin
         dq_s1_q <= flash_dq_in;
         dq_s2_q <= dq_s1_q;
         rsp_q <= (state_q == FIC_DONE);
         // Sample at end of output enable, before the bus is released
         if (state_q == FIC_PULSE && cnt_done && step_read) begin
            // Identification data sits on the low byte only
            rdata_q <= is_id_op ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
         end
      end
   end
   assign rsp_valid = rsp_q;
   assign rsp_rdata = rdata_q;

   // ==========================================================
   // Checks
   sequence we_low_s;
      !flash_we_n;
   endsequence

   write_qual_a: assert property (@(posedge clock) disable iff (reset)
      we_low_s |-> !flash_ce_n && flash_oe_n)
      else $error("write strobe without select or with output enable");
   read_dq_off_a: assert property (@(posedge clock) disable iff (reset)
      !flash_oe_n |-> !flash_dq_oe)
      else $error("data driven during read");
   we_width_a: assert property (@(posedge clock) disable iff (reset)
      $fell(flash_we_n) |-> !flash_we_n [*6])
      else $error("write pulse too short");
   hv_reset_a: assert property (@(posedge clock) disable iff (reset)
      temp_unprotect ##1 !temp_unprotect |=> !high_volt_reset_pin)
      else $error("reset pin voltage not removed");
   hv_id_a: assert property (@(posedge clock) disable iff (reset)
      high_volt_id_addr_bit |-> !flash_ce_n || $past(!flash_ce_n))
      else $error("address nine voltage outside a cycle");
   id_byte_a: assert property (@(posedge clock) disable iff (reset)
      rsp_valid && is_id_op |-> rsp_rdata[15:8] == 8'h00)
      else $error("identification upper byte not zero");
   reset_cmd_a: assert property (@(posedge clock) disable iff (reset)
      !flash_we_n && op_q == fic_pkg::OP_RESET |-> flash_dq_out[7:0] == fic_pkg::RESET_CMD_DATA)
      else $error("reset command data wrong");
   rsp_after_req_a: assert property (@(posedge clock) disable iff (reset)
      start |-> ##[10:120] rsp_valid)
      else $error("no response to request");
endmodule

// ==== rtl/fic_pkg.sv ====
// Constants for the flash identification and protection host controller.
// Assumes a single 125 MHz clock domain.
package fic_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;
   localparam int SECT_W = 7;
   localparam int CLK_PERIOD_NS = 8;
   // Bus cycle phase times in ns
   localparam int T_SETUP_NS = 40;
   localparam int T_PULSE_NS = 56;
   localparam int T_HOLD_NS = 24;
   localparam int T_ACCESS_NS = 80;
   localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] PULSE_CYC = 4'((T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Command words
   localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h002AA;
   localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
   localparam logic [7:0] UNLOCK2_DATA = 8'h55;
   localparam logic [7:0] ID_CMD_DATA = 8'h90;
   localparam logic [7:0] RESET_CMD_DATA = 8'hF0;
   // Identification word offsets, used by both identification methods
   localparam logic [ADDR_W-1:0] ID_MFR_OFS = 19'h00000;
   localparam logic [ADDR_W-1:0] ID_DEV_OFS = 19'h00001;
   localparam logic [ADDR_W-1:0] ID_PROT_OFS = 19'h00002;
   localparam logic [7:0] PROT_SET = 8'h01;
   localparam logic [7:0] PROT_CLR = 8'h00;
   // Operation codes on the user port
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_ID_MFR = 3'h1;
   localparam logic [2:0] OP_ID_DEV = 3'h2;
   localparam logic [2:0] OP_ID_PROT = 3'h3;
   localparam logic [2:0] OP_RESET = 3'h4;
   localparam logic [2:0] OP_WRITE = 3'h5;
endpackage

// ==== bench/fic_flash_model.sv ====
// Behavioural parallel NOR flash: command decode, identification, protection.
// Assumes the host's split data pins; a released bus shows the inverse of the last value.
`timescale 1ns/100ps
module fic_flash_model #(
   parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value
   parameter logic [7:0] DEV_CODE = 8'hA7, // Arbitrary value
   parameter logic [7:0] PROG_CMD = 8'hA0,
   parameter logic [6:0] PROT_SECT = 7'h05
) (
   input wire logic [18:0] addr,
   input wire logic [15:0] dq_host,
   input wire logic dq_host_oe,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic high_volt_id_addr_bit,
   input wire logic hv_rst,
   output logic [15:0] dq
);
   logic [15:0] mem [0:127];
   logic [18:0] wa;
   logic [1:0] seq;
   logic id_mode;
   logic armed;
   logic [15:0] rd;
   logic [15:0] last;
   wire logic wr_ok = !ce_n && oe_n;
   wire logic rd_on = !ce_n && !oe_n;
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 16'hFFFF;
      seq = 2'h0;
      id_mode = 1'b0;
      armed = 1'b0;
      last = 16'h0000;
   end
   // =====
   // Write cycles
   always @(negedge we_n) if (wr_ok) wa = addr;
   always @(posedge we_n) begin
      if (wr_ok) begin
         if (dq[7:0] == fic_pkg::RESET_CMD_DATA) begin
            seq = 2'h0;
            id_mode = 1'b0;
            armed = 1'b0;
         end else if (armed) begin
            if (!(wa[18:12] == PROT_SECT && !hv_rst)) begin
               mem[{wa[14:12], wa[3:0]}] = dq;
            end
            armed = 1'b0;
         end else if (seq == 2'h0 && wa == fic_pkg::UNLOCK1_ADDR && dq[7:0] == 8'hAA) begin
            seq = 2'h1;
         end else if (seq == 2'h1 && wa == fic_pkg::UNLOCK2_ADDR && dq[7:0] == 8'h55) begin
            seq = 2'h2;
         end else if (seq == 2'h2 && wa == fic_pkg::UNLOCK1_ADDR && dq[7:0] == 8'h90) begin
            id_mode = 1'b1;
            seq = 2'h0;
         end else if (seq == 2'h2 && wa == fic_pkg::UNLOCK1_ADDR && dq[7:0] == PROG_CMD) begin
            armed = 1'b1;
            seq = 2'h0;
         end else seq = 2'h0;
      end
   end
   // =====
   // Read data
   always_comb begin
      if ((high_volt_id_addr_bit && !addr[6]) || id_mode) begin
         case (addr[1:0])
            2'h0: rd = {8'h5A, MFR_CODE};
            2'h1: rd = {8'h5A, DEV_CODE};
            2'h2: rd = {8'h5A, 7'h00, addr[18:12] == PROT_SECT};
            default: rd = 16'h5AFF;
         endcase
      end else rd = mem[{addr[14:12], addr[3:0]}];
   end
   always @* if (rd_on) last = rd;
   assign dq = dq_host_oe ? dq_host : (rd_on ? rd : ~last);
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the flash host controller against the flash model.
// Assumes fic_pkg and fic_host are compiled first.
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      logic [2:0] op;
      logic [18:0] a;
      logic [15:0] d;
      logic hv;
      logic [15:0] exp;
      logic chk;
   } fic_row_t;
   localparam fic_row_t ROWS [14] = '{
      '{fic_pkg::OP_READ, 19'h01003, 16'h0000, 1'b0, 16'hFFFF, 1'b1},
      '{fic_pkg::OP_ID_MFR, 19'h00000, 16'h0000, 1'b1, 16'h003C, 1'b1},
      '{fic_pkg::OP_ID_DEV, 19'h00000, 16'h0000, 1'b1, 16'h00A7, 1'b1},
      '{fic_pkg::OP_ID_PROT, 19'h05000, 16'h0000, 1'b1, 16'h0001, 1'b1},
      '{fic_pkg::OP_ID_PROT, 19'h01000, 16'h0000, 1'b1, 16'h0000, 1'b1},
      '{fic_pkg::OP_ID_MFR, 19'h00000, 16'h0000, 1'b0, 16'h003C, 1'b1},
      '{fic_pkg::OP_RESET, 19'h00000, 16'h0000, 1'b0, 16'h0000, 1'b0},
      '{fic_pkg::OP_ID_DEV, 19'h00000, 16'h0000, 1'b0, 16'h00A7, 1'b1},
      '{fic_pkg::OP_RESET, 19'h7FFFF, 16'h0000, 1'b0, 16'h0000, 1'b0},
      '{fic_pkg::OP_ID_PROT, 19'h05000, 16'h0000, 1'b0, 16'h0001, 1'b1},
      '{fic_pkg::OP_RESET, 19'h12345, 16'h0000, 1'b0, 16'h0000, 1'b0},
      '{fic_pkg::OP_READ, 19'h01003, 16'h0000, 1'b0, 16'hFFFF, 1'b1},
      '{fic_pkg::OP_WRITE, 19'h01004, 16'h1111, 1'b0, 16'h0000, 1'b0},
      '{fic_pkg::OP_READ, 19'h01004, 16'h0000, 1'b0, 16'hFFFF, 1'b1}};
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   logic [2:0] req_op = 3'h0;
   logic [18:0] req_addr = 19'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic req_hv_mode = 1'b0;
   logic temp_unprotect = 1'b0;
   logic req_ready, rsp_valid, dq_oe, ce_n, oe_n, we_n, hv_id, hv_rst;
   logic [15:0] rsp_rdata, dq_out, dq_in;
   logic [18:0] faddr;
   int n_fail = 0;
   int total_checks = 0;
   always #4 clock = ~clock;
   fic_host u_fic_host (.clock(clock), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_hv_mode(req_hv_mode), .temp_unprotect(temp_unprotect), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .high_volt_id_addr_bit(hv_id), .high_volt_reset_pin(hv_rst));
   fic_flash_model u_fic_flash_model (.addr(faddr), .dq_host(dq_out), .dq_host_oe(dq_oe),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .high_volt_id_addr_bit(hv_id), .hv_rst(hv_rst),
      .dq(dq_in));
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_word({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic results;
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic do_op(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d,
                        input logic hv);
      int n;
      n = 0;
      req_op = op;
      req_addr = a;
      req_wdata = d;
      req_hv_mode = hv;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) begin
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      #1;
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 300) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (n >= 300) n_fail++;
   endtask
   task automatic rd_chk(input logic [18:0] a, input logic [15:0] exp);
      do_op(fic_pkg::OP_READ, a, 16'h0000, 1'b0);
      check_word(rsp_rdata, exp);
   endtask
   task automatic prog(input logic [18:0] a, input logic [15:0] d, input logic [7:0] u2);
      do_op(fic_pkg::OP_WRITE, fic_pkg::UNLOCK1_ADDR, 16'h00AA, 1'b0);
      do_op(fic_pkg::OP_WRITE, fic_pkg::UNLOCK2_ADDR, {8'h00, u2}, 1'b0);
      do_op(fic_pkg::OP_WRITE, fic_pkg::UNLOCK1_ADDR, 16'h00A0, 1'b0);
      do_op(fic_pkg::OP_WRITE, a, d, 1'b0);
   endtask
   initial begin
      #100000;
      n_fail++;
      results();
   end
   // =====
   // Main sequence
   initial begin
      repeat (2) @(posedge clock);
      #1;
      reset = 1'b0;
      check_bit(ce_n & oe_n & we_n & req_ready & !rsp_valid & !dq_oe, 1'b1);
      foreach (ROWS[i]) begin
         do_op(ROWS[i].op, ROWS[i].a, ROWS[i].d, ROWS[i].hv);
         if (ROWS[i].chk) check_word(rsp_rdata, ROWS[i].exp);
      end
      prog(19'h01003, 16'h1234, 8'h55);
      rd_chk(19'h01003, 16'h1234);
      prog(19'h01002, 16'h4321, 8'h00);
      rd_chk(19'h01002, 16'hFFFF);
      prog(19'h05003, 16'hBEEF, 8'h55);
      rd_chk(19'h05003, 16'hFFFF);
      temp_unprotect = 1'b1;
      prog(19'h05003, 16'hBEEF, 8'h55);
      rd_chk(19'h05003, 16'hBEEF);
      temp_unprotect = 1'b0;
      prog(19'h05004, 16'hCAFE, 8'h55);
      rd_chk(19'h05004, 16'hFFFF);
      do_op(fic_pkg::OP_ID_PROT, 19'h05000, 16'h0000, 1'b1);
      check_word(rsp_rdata, 16'h0001);
      // Reset in mid write: pins fall back to idle, then a read still works
      req_op = fic_pkg::OP_WRITE;
      req_valid = 1'b1;
      repeat (8) @(posedge clock);
      #1;
      reset = 1'b1;
      req_valid = 1'b0;
      #1;
      check_bit(ce_n & oe_n & we_n & req_ready & !dq_oe & !hv_id, 1'b1);
      @(posedge clock);
      #1;
      reset = 1'b0;
      rd_chk(19'h01003, 16'h1234);
      results();
   end
endmodule
